// ---- bsi_regs.svh ----
// Register offsets, field positions, reset values and timing figures of the bus status block.
// Assumes it is included by its bare name wherever these names are needed.
// Behaviour
// RULE_01 - Fetch status only during first instruction byte.
// RULE_02 - Output status: output address, data under write.
// RULE_03 - Input device drives data during input strobe.
// RULE_04 - Memory-read status for memory read cycles.
// RULE_05 - Halt status acknowledges executed halt.
// RULE_06 - Bus clock is inverted phase-2 clock.
// RULE_07 - Panel read enables panel and switch drivers.
// RULE_08 - Panel read disables processor input drivers.
// RULE_09 - I/O devices clear on grounded clear line.
// RULE_10 - Bus carries 60 Hz timing reference.
// RULE_11 - Status strobe loads status early each cycle.
// RULE_12 - Gate select high processor, low panel.
// RULE_13 - Output data stable while write strobe active.
// RULE_14 - Input strobe marks bus accepting data.
// RULE_15 - Sync pulse at every machine cycle start.
// RULE_16 - Status latched on strobe, held whole cycle.
// RULE_17 - One input driver set, switched between cycles.
`ifndef BSI_REGS_SVH
`define BSI_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------
`define BSI_OFF_CTRL   8'h00
`define BSI_OFF_ADDR   8'h04
`define BSI_OFF_WDATA  8'h08
`define BSI_OFF_STATUS 8'h0c
`define BSI_OFF_RDATA  8'h10

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define BSI_CTRL_CMD_LSB   0
`define BSI_CTRL_CMD_MSB   2
`define BSI_CTRL_PANEL_BIT 4
`define BSI_CTRL_GO_BIT    8
`define BSI_STAT_BUSY_BIT  8
`define BSI_STAT_GATE_BIT  9

// ----------------------------------------------------------------
// Reset values and timing.
// ----------------------------------------------------------------
`define BSI_RST_ADDR  16'h0000
`define BSI_RST_DATA  8'h00
`define BSI_RST_STAT  5'h00
`define BSI_PCLK_HZ   200000000
`define BSI_RTC_HZ    60

`endif

// ---- bsi_pkg.sv ----
// Types shared by the bus status block.
// Assumes bsi_regs.svh supplies the numeric constants.
package bsi_pkg;

  // Machine cycle kinds that software may launch.
  typedef enum logic [2:0] {
    CMD_FETCH = 3'h0,
    CMD_MEMRD = 3'h1,
    CMD_MEMWR = 3'h2,
    CMD_IN    = 3'h3,
    CMD_OUT   = 3'h4,
    CMD_HALT  = 3'h5
  } bsi_cmd_t;

  // Machine cycle sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_T1   = 4'h2,
    ST_T2   = 4'h4,
    ST_T3   = 4'h8
  } bsi_state_t;

endpackage

// ---- bsi_sync.sv ----
// Two-stage synchroniser for pins from outside the pclk domain.
// Assumes each bit is either a slow level or stable while sampled.
`timescale 1ns/1ps
`default_nettype none
module bsi_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ---- bsi_rtc_div.sv ----
// Divider that makes the 60 Hz timing reference square wave.
// Assumes pclk runs at the nominal rate; HALF sets the half period.
`timescale 1ns/1ps
`default_nettype none
`include "bsi_regs.svh"
module bsi_rtc_div #(
  parameter int HALF = `BSI_PCLK_HZ / (2 * `BSI_RTC_HZ)
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  output var  logic rtc_q
);

  logic [31:0] cnt_q;

  // Toggle the reference each half period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0000_0000;
      rtc_q <= 1'b0;
    end else if (ce) begin
      if (cnt_q == 32'(HALF - 1)) begin
        cnt_q <= 32'h0000_0000;
        rtc_q <= ~rtc_q; // [RULE_10]
      end else begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  property p_rtc_toggle;
    @(posedge pclk) disable iff (!presetn)
    $changed(rtc_q) |-> $past(cnt_q) == 32'(HALF - 1);
  endproperty
  a_rtc_toggle: assert property (p_rtc_toggle) else $error("rtc toggled early"); // [RULE_10]

endmodule
`default_nettype wire

// ---- bsi_bus_status.sv ----
// Backplane status outputs, cycle strobes and input steering of the processor board.
// Assumes an APB master on pclk and a phase-2 clock pin far slower than pclk.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bsi_regs.svh"
module bsi_bus_status #(
  parameter int RTC_HALF = `BSI_PCLK_HZ / (2 * `BSI_RTC_HZ)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        phase2_clk,
  input  wire logic [7:0]  processor_input_bus,
  input  wire logic [7:0]  panel_input_bus,
  output var  logic        bus_clock,
  output var  logic        first_cycle_fetch_status,
  output var  logic        output_cycle_status,
  output var  logic        input_cycle_status,
  output var  logic        memory_read_status,
  output var  logic        halt_ack_status,
  output var  logic        panel_switch_read,
  output var  logic        status_latch_strobe,
  output var  logic        cycle_start_pulse,
  output var  logic        write_strobe,
  output var  logic        bus_in_strobe,
  output var  logic [15:0] address_bus,
  output var  logic [7:0]  data_out_bus,
  output var  logic        input_gate_select,
  output var  logic        panel_drv_en,
  output var  logic        processor_drv_en,
  output var  logic        rtc_ref
);

  // ----------------------------------------------------------------
  // Decode helpers.
  // ----------------------------------------------------------------
  // Status bits {fetch, out, in, memr, halt} for a cycle kind.
  function automatic logic [4:0] status_of(input bsi_pkg::bsi_cmd_t c);
    logic [4:0] s;
    s = 5'h00;
    unique case (c)
      bsi_pkg::CMD_FETCH: s = 5'h12;
      bsi_pkg::CMD_MEMRD: s = 5'h02;
      bsi_pkg::CMD_MEMWR: s = 5'h00;
      bsi_pkg::CMD_IN:    s = 5'h04;
      bsi_pkg::CMD_OUT:   s = 5'h08;
      bsi_pkg::CMD_HALT:  s = 5'h01;
      default:            s = 5'h00;
    endcase
    return s;
  endfunction

  // True for cycle kinds that take data in.
  function automatic logic reads(input bsi_pkg::bsi_cmd_t c);
    return (c == bsi_pkg::CMD_FETCH) || (c == bsi_pkg::CMD_MEMRD) || (c == bsi_pkg::CMD_IN);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers, timing reference.
  // ----------------------------------------------------------------
  logic       phi2_s;
  logic       phi2_d1_q;
  logic [7:0] proc_in_s;
  logic [7:0] panel_in_s;

  bsi_sync #(.W(1)) u_sync_phi2 (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (phase2_clk),
    .q       (phi2_s)
  );
  bsi_sync #(.W(16)) u_sync_data (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       ({processor_input_bus, panel_input_bus}),
    .q       ({proc_in_s, panel_in_s})
  );
  bsi_rtc_div #(.HALF(RTC_HALF)) u_rtc (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .rtc_q   (rtc_ref)
  );

  logic phi2_rise;
  logic phi2_fall;
  assign phi2_rise = phi2_s & ~phi2_d1_q;
  assign phi2_fall = ~phi2_s & phi2_d1_q;

  // Edge history and the inverted bus clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phi2_d1_q <= 1'b0;
      bus_clock <= 1'b1;
    end else if (ce) begin
      phi2_d1_q <= phi2_s;
      bus_clock <= ~phi2_s; // [RULE_06]
    end
  end

  // ----------------------------------------------------------------
  // APB register file.
  // ----------------------------------------------------------------
  bsi_pkg::bsi_cmd_t  cmd_q;
  bsi_pkg::bsi_state_t st_q;
  logic        panel_q;
  logic        go_q;
  logic [15:0] addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic [4:0]  stat_q;
  logic        gate_q;
  logic        busy;
  logic        wr_en;
  logic        launch;

  assign busy   = go_q || (st_q != bsi_pkg::ST_IDLE);
  assign wr_en  = psel && penable && pwrite && ce;
  assign launch = go_q && phi2_rise && (st_q == bsi_pkg::ST_IDLE);
  assign pready = 1'b1;

  // Software writes; a go while busy or with an illegal kind is ignored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q   <= bsi_pkg::CMD_FETCH;
      panel_q <= 1'b0;
      go_q    <= 1'b0;
      addr_q  <= `BSI_RST_ADDR;
      wdata_q <= `BSI_RST_DATA;
    end else if (ce) begin
      if (launch) begin
        go_q <= 1'b0;
      end
      if (wr_en && !busy) begin
        unique case (paddr)
          `BSI_OFF_CTRL: begin
            cmd_q   <= bsi_pkg::bsi_cmd_t'(pwdata[`BSI_CTRL_CMD_MSB:`BSI_CTRL_CMD_LSB]);
            panel_q <= pwdata[`BSI_CTRL_PANEL_BIT];
            go_q    <= pwdata[`BSI_CTRL_GO_BIT] && (pwdata[`BSI_CTRL_CMD_MSB:`BSI_CTRL_CMD_LSB] <= 3'h5);
          end
          `BSI_OFF_ADDR:  addr_q  <= pwdata[15:0];
          `BSI_OFF_WDATA: wdata_q <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // Read mux and error answer for unmapped addresses.
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      `BSI_OFF_CTRL:   prdata = {23'h0, go_q, 3'h0, panel_q, 1'b0, cmd_q};
      `BSI_OFF_ADDR:   prdata = {16'h0, addr_q};
      `BSI_OFF_WDATA:  prdata = {24'h0, wdata_q};
      `BSI_OFF_STATUS: prdata = {22'h0, gate_q, busy, 3'h0, stat_q};
      `BSI_OFF_RDATA:  prdata = {24'h0, rdata_q};
      default:         pslverr = psel && penable;
    endcase
  end

  // ----------------------------------------------------------------
  // Machine cycle sequencer, stepped by phase-2 rising edges.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= bsi_pkg::ST_IDLE;
    end else if (ce && phi2_rise) begin
      unique case (st_q)
        bsi_pkg::ST_IDLE: if (go_q) st_q <= bsi_pkg::ST_T1;
        bsi_pkg::ST_T1:   st_q <= bsi_pkg::ST_T2;
        bsi_pkg::ST_T2:   st_q <= bsi_pkg::ST_T3;
        bsi_pkg::ST_T3:   st_q <= bsi_pkg::ST_IDLE;
      endcase
    end
  end

  // Sync pulse spans the first state of every cycle.
  assign cycle_start_pulse = (st_q == bsi_pkg::ST_T1); // [RULE_15]

  // Strobe pulse at the phase-2 fall inside the first state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_latch_strobe <= 1'b0;
    end else if (ce) begin
      status_latch_strobe <= cycle_start_pulse && phi2_fall; // [RULE_11]
    end
  end

  // Status latch, input steering and bus drive loaded by the strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q            <= `BSI_RST_STAT;
      panel_switch_read <= 1'b0;
      gate_q            <= 1'b1;
      address_bus       <= `BSI_RST_ADDR;
      data_out_bus      <= `BSI_RST_DATA;
    end else if (ce && status_latch_strobe) begin
      stat_q            <= status_of(cmd_q); // [RULE_16] [RULE_01] [RULE_04] [RULE_05]
      panel_switch_read <= panel_q && (cmd_q == bsi_pkg::CMD_IN); // [RULE_07]
      gate_q            <= !(panel_q && (cmd_q == bsi_pkg::CMD_IN)); // [RULE_17] [RULE_12]
      address_bus       <= addr_q; // [RULE_02]
      data_out_bus      <= wdata_q; // [RULE_13]
    end
  end

  assign {first_cycle_fetch_status, output_cycle_status, input_cycle_status,
          memory_read_status, halt_ack_status} = stat_q;
  assign input_gate_select = gate_q; // [RULE_12]
  assign processor_drv_en  = gate_q; // [RULE_08]
  assign panel_drv_en      = ~gate_q; // [RULE_07]

  // Strobes of the data transfer state; halt moves no data.
  assign write_strobe  = (st_q == bsi_pkg::ST_T2) && !reads(cmd_q)
                         && (cmd_q != bsi_pkg::CMD_HALT); // [RULE_02]
  assign bus_in_strobe = (st_q == bsi_pkg::ST_T2) && reads(cmd_q); // [RULE_14]

  // Capture input data from whichever driver set holds the bus.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= `BSI_RST_DATA;
    end else if (ce && bus_in_strobe && phi2_rise) begin
      rdata_q <= gate_q ? proc_in_s : panel_in_s; // [RULE_03]
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_fetch_only;
    $past(status_latch_strobe) |->
      first_cycle_fetch_status == ($past(cmd_q) == bsi_pkg::CMD_FETCH);
  endproperty
  a_fetch_only: assert property (p_fetch_only) else $error("fetch status wrong"); // [RULE_01]

  property p_out_excl;
    output_cycle_status |-> !input_cycle_status && !memory_read_status && !bus_in_strobe;
  endproperty
  a_out_excl: assert property (p_out_excl) else $error("output status mixed"); // [RULE_02]

  property p_memr_read;
    bus_in_strobe && !input_cycle_status |-> memory_read_status;
  endproperty
  a_memr_read: assert property (p_memr_read) else $error("memory read missing"); // [RULE_04]

  property p_halt_quiet;
    halt_ack_status |-> !write_strobe && !bus_in_strobe;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("halt moved data"); // [RULE_05]

  property p_bus_clock;
    $rose(phi2_s) |=> $fell(bus_clock);
  endproperty
  a_bus_clock: assert property (p_bus_clock) else $error("bus clock not inverted"); // [RULE_06]

  property p_panel_drv;
    panel_switch_read |-> panel_drv_en && !processor_drv_en && !input_gate_select;
  endproperty
  a_panel_drv: assert property (p_panel_drv) else $error("panel steering wrong"); // [RULE_08]

  property p_data_stable;
    write_strobe ##1 write_strobe |-> $stable(data_out_bus) && $stable(address_bus);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved under write"); // [RULE_13]

  property p_sync_strobe;
    $rose(cycle_start_pulse) |-> ##[1:40] status_latch_strobe;
  endproperty
  a_sync_strobe: assert property (p_sync_strobe) else $error("no status strobe"); // [RULE_15]

  property p_status_hold;
    $changed(stat_q) |-> $past(status_latch_strobe);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status changed mid cycle"); // [RULE_16]

  property p_one_driver;
    processor_drv_en != panel_drv_en;
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("driver select wrong"); // [RULE_17]

  // The driver selection may only move with the status load at a cycle start.
  property p_gate_between;
    $changed(gate_q) |-> $past(status_latch_strobe);
  endproperty
  a_gate_between: assert property (p_gate_between) else $error("gate moved mid cycle"); // [RULE_17]

  c_fetch: cover property (first_cycle_fetch_status && bus_in_strobe);
  c_out:   cover property (output_cycle_status && write_strobe);
  c_panel: cover property (panel_switch_read && bus_in_strobe);

endmodule
`default_nettype wire

// ---- bsi_far_boards.sv ----
// Behavioural model of the boards that answer input cycles on the backplane.
// Assumes the strobe and gate select come from the processor board block on pclk.
`timescale 1ns/1ps
`default_nettype none
module bsi_far_boards (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       bus_in_strobe,
  input  wire logic       input_gate_select,
  input  wire logic       io_clear_n,
  input  wire logic [7:0] proc_value,
  input  wire logic [7:0] panel_value,
  output var  logic [7:0] processor_input_bus,
  output var  logic [7:0] panel_input_bus
);
  // --------
  // Driver timing
  // --------
  logic [2:0] hold_q;
  logic       act;
  assign act = bus_in_strobe || (hold_q != 3'h0);
  // Keeps data up a few cycles past the strobe to cover the resync delay.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hold_q <= 3'h0;
    else if (bus_in_strobe)
      hold_q <= 3'h4;
    else if (hold_q != 3'h0)
      hold_q <= hold_q - 3'h1;
  end
  // Only the selected set drives; an idle bus flips every cycle so stale data never passes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      processor_input_bus <= 8'h5a;
      panel_input_bus     <= 8'ha5;
    end else begin
      // A grounded clear line holds the I/O device cleared, so it answers zero.
      if (act && input_gate_select && !io_clear_n)
        processor_input_bus <= 8'h00;
      else if (act && input_gate_select)
        processor_input_bus <= proc_value;
      else
        processor_input_bus <= ~processor_input_bus;
      if (act && !input_gate_select)
        panel_input_bus <= panel_value;
      else
        panel_input_bus <= ~panel_input_bus;
    end
  end
endmodule
`default_nettype wire

// ---- tb_bsi_bus_status.sv ----
// Self-checking bench for the bus status block: APB tasks and machine cycle tests.
// Assumes bsi_far_boards answers input cycles and a short timing reference divider.
`timescale 1ns/1ps
`default_nettype none
`include "bsi_regs.svh"
module tb_bsi_bus_status;
  localparam int RTC_HALF = 10;
  logic        pclk, presetn, ce, psel, penable, pwrite, phase2_clk, pready, pslverr;
  logic        bus_clock, fetch_s, out_s, in_s, memr_s, halt_s, pan_rd, stb, sync_p;
  logic        wr_s, din_s, gate, pan_en, proc_en, rtc_ref, re, stb_q, wr_q, sync_q, din_q;
  logic        io_clr_n;
  logic [7:0]  paddr, proc_bus, panel_bus, proc_value, panel_value, data_out_bus, dout_q;
  logic [15:0] address_bus;
  logic [31:0] pwdata, prdata, rq;
  logic [29:0] cur, cur_q;
  int          err_count = 0, comparisons = 0, cyc = 0, s0, n;
  int          n_sync = 0, n_stb = 0, n_wr = 0, n_din = 0;
  assign cur = {fetch_s, out_s, in_s, memr_s, halt_s, gate, address_bus, data_out_bus};

  bsi_bus_status #(.RTC_HALF(RTC_HALF)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase2_clk(phase2_clk),
    .processor_input_bus(proc_bus), .panel_input_bus(panel_bus), .bus_clock(bus_clock),
    .first_cycle_fetch_status(fetch_s), .output_cycle_status(out_s),
    .input_cycle_status(in_s), .memory_read_status(memr_s), .halt_ack_status(halt_s),
    .panel_switch_read(pan_rd), .status_latch_strobe(stb), .cycle_start_pulse(sync_p),
    .write_strobe(wr_s), .bus_in_strobe(din_s), .address_bus(address_bus),
    .data_out_bus(data_out_bus), .input_gate_select(gate), .panel_drv_en(pan_en),
    .processor_drv_en(proc_en), .rtc_ref(rtc_ref));
  bsi_far_boards u_far (.pclk(pclk), .presetn(presetn), .bus_in_strobe(din_s),
    .input_gate_select(gate), .io_clear_n(io_clr_n), .proc_value(proc_value),
    .panel_value(panel_value),
    .processor_input_bus(proc_bus), .panel_input_bus(panel_bus));

  // --------
  // Clocks, checks and bus tasks
  // --------
  // Makes pclk and an unrelated free-running phase-2 clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    phase2_clk = 1'b0;
    #3.1;
    forever #62.5 phase2_clk = ~phase2_clk;
  end
  task automatic chk_w(input logic [31:0] g, input logic [31:0] x, input string m);
    comparisons++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task automatic chk_b(input logic g, input logic x, input string m);
    chk_w({31'h0, g}, {31'h0, x}, m);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      close_out();
    end
  end
  // Watches latched pins and driver enables each cycle and counts strobe rises.
  always @(posedge pclk) begin
    if (presetn) begin
      if (cur != cur_q) chk_b(stb_q, 1'b1, "latched pins moved off strobe");
      if (wr_s && wr_q) chk_w(data_out_bus, dout_q, "data moved under write");
      chk_b(proc_en ^ pan_en, 1'b1, "one driver set");
      chk_b(proc_en, gate, "processor drivers follow gate");
      n_sync <= n_sync + int'(sync_p && !sync_q);
      n_stb <= n_stb + int'(stb && !stb_q);
      n_wr <= n_wr + int'(wr_s && !wr_q);
      n_din <= n_din + int'(din_s && !din_q);
    end
    cur_q <= cur;
    stb_q <= stb;
    wr_q <= wr_s;
    sync_q <= sync_p;
    din_q <= din_s;
    dout_q <= data_out_bus;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_busy(input logic v);
    for (int k = 0; k < 100; k++) begin
      apb(1'b0, `BSI_OFF_STATUS, 32'h0);
      if (rq[`BSI_STAT_BUSY_BIT] === v) return;
    end
    chk_b(~v, v, "busy wait");
  endtask
  function automatic logic [4:0] exp_stat(input logic [2:0] c);
    case (c)
      3'h0: return 5'b10010;
      3'h1: return 5'b00010;
      3'h3: return 5'b00100;
      3'h4: return 5'b01000;
      3'h5: return 5'b00001;
      default: return 5'b00000;
    endcase
  endfunction
  // Runs one machine cycle and checks pins, registers and strobe counts.
  task automatic run(input logic [2:0] c, input logic pn, input logic [3:0] i);
    logic [15:0] a;
    logic [7:0]  d;
    logic        ip;
    int          b0, w0, i0;
    a = {i, 4'ha, ~i, 4'h5};
    d = {4'h9, i};
    ip = pn && c == 3'h3;
    proc_value <= {4'h6, i};
    panel_value <= {4'hc, i};
    apb(1'b1, `BSI_OFF_ADDR, {16'h0, a});
    apb(1'b1, `BSI_OFF_WDATA, {24'h0, d});
    repeat (2) @(posedge phase2_clk);
    s0 = n_sync;
    b0 = n_stb;
    w0 = n_wr;
    i0 = n_din;
    apb(1'b1, `BSI_OFF_CTRL, {23'h0, 1'b1, 3'h0, pn, 1'b0, c});
    wait_busy(1'b1);
    apb(1'b1, `BSI_OFF_ADDR, {16'h0, ~a});
    wait_busy(1'b0);
    #1;
    chk_w({fetch_s, out_s, in_s, memr_s, halt_s}, exp_stat(c), "status pins");
    chk_w({address_bus, data_out_bus}, {a, d}, "address and data out");
    chk_w({pan_rd, gate, pan_en}, {ip, ~ip, ip}, "input steering");
    chk_w(32'(n_sync - s0), 32'h1, "cycle start pulses");
    chk_w(32'(n_stb - b0), 32'h1, "status strobes");
    chk_w(32'(n_wr - w0), {31'h0, c == 3'h2 || c == 3'h4}, "write strobes");
    chk_w(32'(n_din - i0), {31'h0, c < 3'h2 || c == 3'h3}, "bus in strobes");
    apb(1'b0, `BSI_OFF_STATUS, 32'h0);
    chk_w(rq, {22'h0, ~ip, 1'b0, 3'h0, exp_stat(c)}, "status word");
    apb(1'b0, `BSI_OFF_ADDR, 32'h0);
    chk_w(rq, {16'h0, a}, "address kept while busy");
    apb(1'b0, `BSI_OFF_RDATA, 32'h0);
    if (c < 3'h2 || c == 3'h3)
      chk_w(rq, {24'h0, ip ? {4'hc, i} : (io_clr_n ? {4'h6, i} : 8'h00)}, "input data");
    $display("test cycle %0d cmd %0d done", i, c);
  endtask

  // --------
  // Test sequence
  // --------
  // Resets the block, then checks reset state, clocks, cycles and refusals.
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ce = 1'b1;
    io_clr_n = 1'b1;
    presetn = 1'b0;
    proc_value = 8'h00;
    panel_value = 8'h00;
    repeat (11) @(posedge pclk);
    #1;
    chk_w({fetch_s, out_s, in_s, memr_s, halt_s, pan_rd, stb, sync_p, wr_s, din_s}, 32'h0, "reset");
    chk_w({bus_clock, gate, proc_en, pan_en, rtc_ref}, 32'h1c, "reset levels");
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `BSI_OFF_STATUS, 32'hffffffff);
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0);
      chk_w(rq, (k == 3) ? 32'h200 : 32'h0, "register reset value");
      chk_b(re, 1'b0, "mapped access error");
    end
    apb(1'b1, 8'h14, 32'h1);
    chk_b(re, 1'b1, "unmapped write error");
    apb(1'b0, 8'h14, 32'h0);
    chk_w({re, rq[30:0]}, 32'h80000000, "unmapped read");
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      @(phase2_clk);
      repeat (8) @(posedge pclk);
      #1;
      chk_b(bus_clock, ~phase2_clk, "bus clock");
    end
    n = 0;
    @(posedge rtc_ref);
    while (rtc_ref === 1'b1 && n < 100) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk_w(32'(n), 32'(RTC_HALF), "timing reference half period");
    $display("test clocks done");
    for (int k = 0; k < 6; k++) run(3'(k), 1'b0, 4'(k));
    run(3'h3, 1'b1, 4'h6);
    run(3'h0, 1'b1, 4'h7);
    io_clr_n <= 1'b0;
    run(3'h3, 1'b0, 4'h8);
    io_clr_n <= 1'b1;
    s0 = n_sync;
    apb(1'b1, `BSI_OFF_CTRL, 32'h107);
    repeat (4) @(posedge phase2_clk);
    apb(1'b0, `BSI_OFF_STATUS, 32'h0);
    chk_w({rq[8], 31'(n_sync - s0)}, 32'h0, "bad command ignored");
    $display("test bad command done");
    close_out();
  end
endmodule
`default_nettype wire
